// ===== rtl/wdr_watchdog_reset.sv
// Watchdog timer, reset-cause flags and brown-out reset sequencing
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module wdr_watchdog_reset #(
   parameter int WDT_BASE_CYC = wdr_pkg::WDT_BASE_CYC,
   parameter int STARTUP_CYC = wdr_pkg::STARTUP_CYC_DEF
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // AXI4-Lite write channels
   input wire logic [wdr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read channels
   input wire logic [wdr_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Fuses and analog detector levels
   input wire logic always_on_fuse_i,
   input wire logic [1:0] undervoltage_level_fuse_i,
   input wire logic low_supply_i,
   input wire logic supply_above_upper_i,
   // Other reset sources and core events
   input wire logic pin_reset_n_i,
   input wire logic debug_reset_i,
   input wire logic kick_i,
   // Reset and reference outputs
   output logic chip_reset_o,
   output logic timeout_pulse_o,
   output logic bandgap_en_o
);

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [wdr_pkg::ADDR_W-1:0] aw_addr;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] win_cnt;
      logic wde;
      logic [wdr_pkg::PSEL_W-1:0] psel;
      logic [1:0] ana;
      logic [wdr_pkg::CAUSE_W-1:0] cause;
      logic [wdr_pkg::DIP_W-1:0] dip_cnt;
      logic bo;
      logic [wdr_pkg::DLY_W-1:0] dly;
      logic chip_rst;
      logic wdt_pulse;
      logic bg_on;
      logic [wdr_pkg::DIV_W-1:0] div_cnt;
      logic [wdr_pkg::WDT_CNT_W-1:0] wd_cnt;
   } wdr_state_t;

   wdr_state_t s_q;
   wdr_state_t s_d;

   logic level2;
   logic bo_en;
   logic wd_en;
   logic wr_go;
   logic wr_ctrl;
   logic wr_cause;
   logic src;
   logic tick;
   logic new_ce;
   logic new_en;
   logic [wdr_pkg::CAUSE_W-1:0] set_v;
   logic [wdr_pkg::WDT_CNT_W-1:0] limit;
   logic [31:0] rd_word;
   logic rd_ok;

   assign level2 = always_on_fuse_i;
   assign bo_en = undervoltage_level_fuse_i != wdr_pkg::BO_FUSE_OFF;
   assign wd_en = s_q.wde | level2;
   assign new_ce = s_q.w_data[wdr_pkg::CTRL_CE];
   assign new_en = s_q.w_data[wdr_pkg::CTRL_EN];
   assign src = !pin_reset_n_i | s_q.bo | debug_reset_i | s_q.wdt_pulse;
   // Doubling from the base count gives the eight periods
   assign limit = wdr_pkg::WDT_CNT_W'(WDT_BASE_CYC) << s_q.psel;

   always_comb begin
      s_d = s_q;
      s_d.wdt_pulse = 1'b0;
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      tick = 1'b0;

      // Write address and data are taken in either order
      if (s_axi_awvalid_i && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata_i[7:0];
         s_d.w_lane0 = s_axi_wstrb_i[0];
      end
      wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      wr_ctrl = wr_go && s_q.w_lane0 && s_q.aw_addr == wdr_pkg::ADDR_CTRL;
      wr_cause = wr_go && s_q.w_lane0 &&
         s_q.aw_addr == wdr_pkg::ADDR_CAUSE;
      if (wr_go) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         unique case (s_q.aw_addr)
            wdr_pkg::ADDR_CAUSE, wdr_pkg::ADDR_CTRL,
            wdr_pkg::ADDR_ANALOG, wdr_pkg::ADDR_STATUS:
               s_d.bresp = wdr_pkg::RESP_OKAY;
            default: s_d.bresp = wdr_pkg::RESP_SLVERR;
         endcase
         if (s_q.w_lane0 && s_q.aw_addr == wdr_pkg::ADDR_ANALOG) begin
            s_d.ana = s_q.w_data[1:0];
         end
      end
      if (s_q.bvalid && s_axi_bready_i) begin
         s_d.bvalid = 1'b0;
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      // Read path
      unique case (s_axi_araddr_i)
         wdr_pkg::ADDR_CAUSE: rd_word[wdr_pkg::CAUSE_W-1:0] = s_q.cause;
         wdr_pkg::ADDR_CTRL: begin
            rd_word[wdr_pkg::CTRL_CE] = s_q.win_cnt != 3'h0;
            rd_word[wdr_pkg::CTRL_EN] = wd_en;
            rd_word[wdr_pkg::PSEL_LSB +: wdr_pkg::PSEL_W] = s_q.psel;
         end
         wdr_pkg::ADDR_ANALOG: rd_word[1:0] = s_q.ana;
         wdr_pkg::ADDR_STATUS: begin
            rd_word[wdr_pkg::STS_CHIP_RST] = s_q.chip_rst;
            rd_word[wdr_pkg::STS_BROWNOUT] = s_q.bo;
            rd_word[wdr_pkg::STS_BANDGAP] = s_q.bg_on;
            rd_word[wdr_pkg::STS_LEVEL2] = level2;
         end
         default: rd_ok = 1'b0;
      endcase
      if (s_axi_arvalid_i && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_word;
         s_d.rresp = rd_ok ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
      end
      if (s_q.rvalid && s_axi_rready_i) begin
         s_d.rvalid = 1'b0;
      end
      s_d.arready = !s_d.rvalid;

      // Unlock window and control fields
      if (s_q.win_cnt != 3'h0) begin
         s_d.win_cnt = s_q.win_cnt - 3'h1;
      end
      if (wr_ctrl) begin
         if (new_ce && new_en) begin
            s_d.win_cnt = wdr_pkg::CE_WINDOW;
            s_d.wde = 1'b1;
         end else if (s_q.win_cnt != 3'h0 && !new_ce) begin
            // Level two ignores the enable value through wd_en
            s_d.psel = s_q.w_data[wdr_pkg::PSEL_LSB +: wdr_pkg::PSEL_W];
            s_d.wde = new_en;
            s_d.win_cnt = 3'h0;
         end else if (new_en) begin
            s_d.wde = 1'b1;
         end
      end

      // Brown-out filter and hysteresis
      if (!bo_en) begin
         s_d.dip_cnt = '0;
         s_d.bo = 1'b0;
      end else if (s_q.bo) begin
         s_d.dip_cnt = '0;
         if (supply_above_upper_i) begin
            s_d.bo = 1'b0;
         end
      end else if (low_supply_i) begin
         // Must stay low longer than the minimum width
         if (s_q.dip_cnt == wdr_pkg::DIP_W'(wdr_pkg::MIN_DIP_CYC)) begin
            s_d.bo = 1'b1;
         end else begin
            s_d.dip_cnt = s_q.dip_cnt + wdr_pkg::DIP_W'(1);
         end
      end else begin
         s_d.dip_cnt = '0;
      end

      s_d.bg_on = bo_en | s_q.ana[wdr_pkg::ANA_CMP_REF] |
         s_q.ana[wdr_pkg::ANA_ADC_EN];

      // Oscillator rate as a tick; one clock means no crossing hazard
      if (s_q.div_cnt == wdr_pkg::DIV_W'(wdr_pkg::WDT_DIV - 1)) begin
         s_d.div_cnt = '0;
         tick = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + wdr_pkg::DIV_W'(1);
      end

      // Watchdog counter
      if (s_q.chip_rst || !wd_en || kick_i) begin
         s_d.wd_cnt = '0;
      end else if (tick) begin
         if (s_q.wd_cnt == limit - wdr_pkg::WDT_CNT_W'(1)) begin
            s_d.wd_cnt = '0;
            s_d.wdt_pulse = 1'b1;
         end else begin
            s_d.wd_cnt = s_q.wd_cnt + wdr_pkg::WDT_CNT_W'(1);
         end
      end

      // Start-up delay restarts while any source is active
      if (src) begin
         s_d.dly = wdr_pkg::DLY_W'(STARTUP_CYC);
      end else if (s_q.dly != '0) begin
         s_d.dly = s_q.dly - wdr_pkg::DLY_W'(1);
      end
      s_d.chip_rst = src || s_q.dly != '0;

      // Reset-cause flags: a set beats a software clear
      set_v = '0;
      set_v[wdr_pkg::CAUSE_DBG] = debug_reset_i;
      set_v[wdr_pkg::CAUSE_WDT] = s_q.wdt_pulse;
      set_v[wdr_pkg::CAUSE_BO] = s_q.bo;
      set_v[wdr_pkg::CAUSE_PIN] = !pin_reset_n_i;
      for (int i = 0; i < wdr_pkg::CAUSE_W; i++) begin
         s_d.cause[i] = set_v[i] |
            (s_q.cause[i] & !(wr_cause && !s_q.w_data[i]));
      end

      // Internal chip reset restores the control register
      if (s_q.chip_rst) begin
         s_d.wde = 1'b0;
         s_d.psel = wdr_pkg::PSEL_RESET;
         s_d.win_cnt = 3'h0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_q <= '0;
         s_q.cause <= wdr_pkg::CAUSE_RESET;
         s_q.chip_rst <= 1'b1;
         s_q.dly <= wdr_pkg::DLY_W'(STARTUP_CYC);
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready_o = s_q.awready;
   assign s_axi_wready_o = s_q.wready;
   assign s_axi_bvalid_o = s_q.bvalid;
   assign s_axi_bresp_o = s_q.bresp;
   assign s_axi_arready_o = s_q.arready;
   assign s_axi_rvalid_o = s_q.rvalid;
   assign s_axi_rdata_o = s_q.rdata;
   assign s_axi_rresp_o = s_q.rresp;
   assign chip_reset_o = s_q.chip_rst;
   assign timeout_pulse_o = s_q.wdt_pulse;
   assign bandgap_en_o = s_q.bg_on;

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   localparam int DIP_LIM = wdr_pkg::MIN_DIP_CYC;
   logic quiet;
   logic open_wr;
   assign quiet = !wr_ctrl && !s_q.chip_rst;
   assign open_wr = wr_ctrl && new_ce && new_en && !s_q.chip_rst;

   property p_pulse_one;
      s_q.wdt_pulse |=> !s_q.wdt_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("watchdog pulse longer than one cycle");

   property p_pulse_delay;
      s_q.wdt_pulse |=> s_q.chip_rst &&
         s_q.dly == wdr_pkg::DLY_W'(STARTUP_CYC);
   endproperty
   a_pulse_delay: assert property (p_pulse_delay)
      else $error("delay counter not started by watchdog pulse");

   property p_pulse_flag;
      s_q.wdt_pulse |=> s_q.cause[wdr_pkg::CAUSE_WDT];
   endproperty
   a_pulse_flag: assert property (p_pulse_flag)
      else $error("timeout flag not set after expiry");

   property p_window_four;
      open_wr ##1 quiet [*4] |=> s_q.win_cnt == 3'h0;
   endproperty
   a_window_four: assert property (p_window_four)
      else $error("change enable not closed after four cycles");

   property p_window_open;
      open_wr |=> s_q.win_cnt == wdr_pkg::CE_WINDOW ##1 s_q.win_cnt != 0;
   endproperty
   a_window_open: assert property (p_window_open)
      else $error("unlock window not opened");

   property p_psel_locked;
      wr_ctrl && s_q.win_cnt == 3'h0 |=> $stable(s_q.psel);
   endproperty
   a_psel_locked: assert property (p_psel_locked)
      else $error("period changed outside unlock window");

   property p_no_clear;
      wr_ctrl && s_q.win_cnt == 3'h0 && s_q.wde && !s_q.chip_rst
         |=> s_q.wde;
   endproperty
   a_no_clear: assert property (p_no_clear)
      else $error("enable cleared without change enable");

   // Counter must run at level two even with the enable bit clear
   property p_level2_on;
      level2 && !s_q.chip_rst && !kick_i && tick && s_q.wd_cnt == '0 &&
         limit > wdr_pkg::WDT_CNT_W'(1) |=> s_q.wd_cnt != '0;
   endproperty
   a_level2_on: assert property (p_level2_on)
      else $error("level two watchdog not running");

   property p_dip_short;
      !s_q.bo && s_q.dip_cnt < wdr_pkg::DIP_W'(DIP_LIM) |=> !s_q.bo;
   endproperty
   a_dip_short: assert property (p_dip_short)
      else $error("brown-out taken from a short dip");

   property p_kick;
      kick_i |=> s_q.wd_cnt == '0;
   endproperty
   a_kick: assert property (p_kick)
      else $error("kick did not clear the counter");

   property p_disabled;
      !wd_en |=> s_q.wd_cnt == '0;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled watchdog counter not cleared");

   property p_por_flag;
      s_q.cause[wdr_pkg::CAUSE_POR] && !wr_cause
         |=> s_q.cause[wdr_pkg::CAUSE_POR];
   endproperty
   a_por_flag: assert property (p_por_flag)
      else $error("power-on flag lost without a write");

   property p_bandgap;
      bo_en |=> s_q.bg_on;
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap off while detector enabled");

   c_expire: cover property (s_q.wdt_pulse);
   c_unlock: cover property (open_wr ##[1:4] wr_ctrl && !new_ce);
   c_brownout: cover property ($rose(s_q.bo));
   c_slverr: cover property (s_q.bvalid &&
      s_q.bresp == wdr_pkg::RESP_SLVERR);

endmodule // wdr_watchdog_reset

// ===== rtl/wdr_pkg.sv
// Constants shared by the watchdog and reset-cause block
package wdr_pkg;

   // Register bus
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_ANALOG = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Reset-cause flag positions
   localparam int CAUSE_W = 5;
   localparam int CAUSE_DBG = 4;
   localparam int CAUSE_WDT = 3;
   localparam int CAUSE_BO = 2;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_POR = 0;
   localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;

   // Watchdog control fields
   localparam int CTRL_CE = 4;
   localparam int CTRL_EN = 3;
   localparam int PSEL_W = 3;
   localparam int PSEL_LSB = 0;
   localparam logic [PSEL_W-1:0] PSEL_RESET = 3'h0;

   // Analog control and status fields
   localparam int ANA_CMP_REF = 0;
   localparam int ANA_ADC_EN = 1;
   localparam int STS_CHIP_RST = 0;
   localparam int STS_BROWNOUT = 1;
   localparam int STS_BANDGAP = 2;
   localparam int STS_LEVEL2 = 3;

   // Undervoltage level fuse code meaning "detector off"
   localparam logic [1:0] BO_FUSE_OFF = 2'h3;

   // Timing
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int WDT_OSC_HZ = 1_000_000;
   localparam int WDT_DIV = SYS_CLK_HZ / WDT_OSC_HZ;
   localparam int DIV_W = 5;
   localparam int MIN_DIP_NS = 2000;
   localparam int MIN_DIP_CYC =
      (MIN_DIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIP_W = 6;
   localparam logic [2:0] CE_WINDOW = 3'h4;
   localparam int WDT_BASE_CYC = 16384;
   localparam int WDT_CNT_W = 22;
   localparam int STARTUP_CYC_DEF = 1024;
   localparam int DLY_W = 16;

endpackage

// ===== sim/wdr_watchdog_reset_tb.sv
// Self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ns
module wdr_watchdog_reset_tb;
   // Short counts keep the run brief
   localparam int BASE = 4;
   localparam int STUP = 8;
   logic sys_clk_i, reset_i;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, uv_fuse;
   logic ao_fuse, low_sup, above_up, pin_rst_n, dbg_rst, kick;
   logic chip_reset_o, timeout_pulse_o, bandgap_en_o;
   int error_cnt = 0;
   int num_checks = 0;

   wdr_watchdog_reset #(.WDT_BASE_CYC(BASE), .STARTUP_CYC(STUP))
         wdr_watchdog_reset_i (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .always_on_fuse_i(ao_fuse),
      .undervoltage_level_fuse_i(uv_fuse), .low_supply_i(low_sup),
      .supply_above_upper_i(above_up), .pin_reset_n_i(pin_rst_n),
      .debug_reset_i(dbg_rst), .kick_i(kick),
      .chip_reset_o(chip_reset_o), .timeout_pulse_o(timeout_pulse_o),
      .bandgap_en_o(bandgap_en_o)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Core stays in reset until the start-up delay runs out
   task automatic do_reset();
      int m;
      @(posedge sys_clk_i);
      reset_i <= 1'b1;
      repeat (16) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      wait_release(m);
      chk(m, STUP + 2);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er = wdr_pkg::RESP_OKAY);
      int n = 0;
      @(posedge sys_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge sys_clk_i);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            chk(bresp, er);
            bready <= 1'b0;
            break;
         end
         if (++n > 50) begin
            chk(32'h0000_0001, 32'h0000_0000);
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e, input logic [1:0] er = wdr_pkg::RESP_OKAY);
      int n = 0;
      @(posedge sys_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge sys_clk_i);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            chk(rdata & m, e);
            chk(rresp, er);
            rready <= 1'b0;
            break;
         end
         if (++n > 50) begin
            chk(32'h0000_0001, 32'h0000_0000);
            break;
         end
      end
   endtask

   // Open the unlock window, then write the wanted value right behind it
   task automatic ctrl_seq(input logic [31:0] d);
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_0018);
      wr(wdr_pkg::ADDR_CTRL, d);
   endtask

   task automatic pulse_kick();
      @(posedge sys_clk_i);
      kick <= 1'b1;
      @(posedge sys_clk_i);
      kick <= 1'b0;
   endtask

   // Counts cycles until chip reset drops, bounded
   task automatic wait_release(output int m);
      m = 0;
      while (chip_reset_o !== 1'b0 && m < 200) begin
         @(posedge sys_clk_i);
         m++;
      end
   endtask

   task automatic wait_pulse(input int lo, input int hi);
      int n = 0;
      int m;
      while (timeout_pulse_o !== 1'b1 && n < hi + 10) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk((n >= lo) && (n <= hi), 1'b1);
      @(posedge sys_clk_i);
      chk(timeout_pulse_o, 1'b0);
      @(posedge sys_clk_i);
      chk(chip_reset_o, 1'b1);
      wait_release(m);
      chk((m >= STUP - 1) && (m <= STUP + 4), 1'b1);
   endtask

   task automatic t_ctrl();
      rd(wdr_pkg::ADDR_CAUSE, 32'hffff_ffff, 32'h0000_0001);
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_00e8);
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0008);
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0008);
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_000f);
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0008);
      pulse_kick();
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_0018);
      repeat (8) @(posedge sys_clk_i);
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0008);
      ctrl_seq(32'h0000_0000);
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
      rd(8'h10, 32'hffff_ffff, 32'h0, wdr_pkg::RESP_SLVERR);
      wr(8'h10, 32'h0000_0008, wdr_pkg::RESP_SLVERR);
      wr(wdr_pkg::ADDR_STATUS, 32'h0000_00ff);
      // Low byte lane off: the write must not land
      wstrb <= 4'he;
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_0008);
      wstrb <= 4'hf;
      rd(wdr_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
   endtask

   task automatic t_period();
      for (int c = 0; c < 8; c++) begin
         ctrl_seq(32'h0000_0008 | c);
         rd(wdr_pkg::ADDR_CTRL, 32'hff, 32'h0000_0008 | c);
         if (c < 3) begin
            wait_pulse((80 << c) - 40, (80 << c) + 25);
            rd(wdr_pkg::ADDR_CTRL, 32'hff, 32'h0000_0000);
            rd(wdr_pkg::ADDR_CAUSE, 32'h08, 32'h0000_0008);
         end else begin
            ctrl_seq(32'h0000_0000);
         end
      end
   endtask

   task automatic t_kick();
      logic seen = 1'b0;
      wr(wdr_pkg::ADDR_CTRL, 32'h0000_0008);
      repeat (10) begin
         repeat (50) begin
            @(posedge sys_clk_i);
            seen |= timeout_pulse_o;
         end
         pulse_kick();
      end
      chk(seen, 1'b0);
      ctrl_seq(32'h0000_0000);
      repeat (200) begin
         @(posedge sys_clk_i);
         seen |= timeout_pulse_o;
      end
      chk(seen, 1'b0);
   endtask

   task automatic t_sources();
      logic seen = 1'b0;
      int m;
      for (int i = 0; i < 4; i++) begin
         wr(wdr_pkg::ADDR_ANALOG, i);
         repeat (3) @(posedge sys_clk_i);
         chk(bandgap_en_o, i != 0);
      end
      rd(wdr_pkg::ADDR_ANALOG, 32'hff, 32'h0000_0003);
      // Detector still fused off, so clearing these bits drops the reference
      wr(wdr_pkg::ADDR_ANALOG, 32'h0000_0000);
      wr(wdr_pkg::ADDR_CAUSE, 32'h0000_0000);
      rd(wdr_pkg::ADDR_CAUSE, 32'hff, 32'h0000_0000);
      pin_rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      pin_rst_n <= 1'b1;
      wait_release(m);
      rd(wdr_pkg::ADDR_CAUSE, 32'hff, 32'h0000_0002);
      dbg_rst <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      dbg_rst <= 1'b0;
      wait_release(m);
      rd(wdr_pkg::ADDR_CAUSE, 32'hff, 32'h0000_0012);
      wr(wdr_pkg::ADDR_CAUSE, 32'h0000_00ff);
      rd(wdr_pkg::ADDR_CAUSE, 32'hff, 32'h0000_0012);
      wr(wdr_pkg::ADDR_CAUSE, 32'h0000_0000);
      // Detector on from here, so the reference must stay up
      uv_fuse <= 2'h0;
      repeat (3) @(posedge sys_clk_i);
      chk(bandgap_en_o, 1'b1);
      above_up <= 1'b0;
      low_sup <= 1'b1;
      repeat (30) begin
         @(posedge sys_clk_i);
         seen |= chip_reset_o;
      end
      low_sup <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      chk(seen, 1'b0);
      low_sup <= 1'b1;
      repeat (50) @(posedge sys_clk_i);
      chk(chip_reset_o, 1'b1);
      low_sup <= 1'b0;
      above_up <= 1'b1;
      wait_release(m);
      chk((m >= STUP) && (m <= STUP + 5), 1'b1);
      rd(wdr_pkg::ADDR_CAUSE, 32'hff, 32'h0000_0004);
   endtask

   task automatic t_level2();
      ao_fuse <= 1'b1;
      do_reset();
      rd(wdr_pkg::ADDR_CTRL, 32'hff, 32'h0000_0008);
      rd(wdr_pkg::ADDR_STATUS, 32'hff, 32'h0000_000c);
      ctrl_seq(32'h0000_0001);
      rd(wdr_pkg::ADDR_CTRL, 32'hff, 32'h0000_0009);
      wait_pulse(100, 200);
      rd(wdr_pkg::ADDR_CTRL, 32'hff, 32'h0000_0008);
      rd(wdr_pkg::ADDR_CAUSE, 32'hff, 32'h0000_0009);
   endtask

   initial begin
      reset_i = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      ao_fuse = 1'b0;
      uv_fuse = 2'h3;
      low_sup = 1'b0;
      above_up = 1'b1;
      pin_rst_n = 1'b1;
      dbg_rst = 1'b0;
      kick = 1'b0;
      do_reset();
      t_ctrl();
      t_period();
      t_kick();
      t_sources();
      t_level2();
      summarize();
   end

   // Whole run needs well under this many cycles
   initial begin
      #(30_000 * 50);
      chk(32'h0000_0001, 32'h0000_0000);
      summarize();
   end
endmodule // wdr_watchdog_reset_tb
